/* File: rtl/lamp_ctrl_pkg.sv */
// Constants, modes and carrier types of the serial port and mode control
package lamp_ctrl_pkg;
   // =====================================================================
   // Frame layout
   localparam int unsigned FRAME_BITS  = 16;
   localparam int unsigned CNT_W       = 5;
   localparam logic [4:0]  FRAME_LEN   = 5'h10;
   localparam int unsigned WD_BIT      = 15;
   localparam int unsigned ADDR_MSB    = 14;
   localparam int unsigned ADDR_LSB    = 10;
   localparam int unsigned ADDR_W      = 5;
   localparam int unsigned DATA_W      = 10;
   localparam int unsigned NCH         = 4;
   // =====================================================================
   // Reset values
   localparam logic [15:0] WORD_RST    = 16'h0000;
   localparam logic [9:0]  CFG_RST     = 10'h000;
   // =====================================================================
   // Timing
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned WD_TIMEOUT_US = 50000;
   localparam int unsigned WD_CYCLES    = WD_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned QUAL_NS      = 20;
   localparam int unsigned QUAL_CYCLES  = (QUAL_NS * CLK_MHZ + 999) / 1000;
   localparam logic [2:0]  QUAL_MAX     = 3'(QUAL_CYCLES);

   // =====================================================================
   // Operating modes
   typedef enum logic [1:0] {
      MODE_SLEEP,
      MODE_NORMAL,
      MODE_FAILSAFE,
      MODE_FAULT
   } op_mode_e;

   // Per-channel fault flags
   typedef struct packed {
      logic [NCH-1:0] overcurrent_flag;
      logic [NCH-1:0] overtemp_flag;
      logic [NCH-1:0] severe_short_flag;
   } chan_fault_s;

   // Device-wide supply flags
   typedef struct packed {
      logic undervoltage_flag;
      logic overvoltage_flag;
      logic overvoltage_disable;
      logic logic_supply_fail;
      logic supply_fail_det_en;
   } supply_s;
endpackage

/* File: rtl/spi_port_and_mode_control.sv */
// Serial slave port, wake/fail/fault terms and mode selection
// Notes on behaviour
// - Fault flag output pulled low whenever any fault term is true
// - Reset low clears configuration and the latched write address and data; sleeps if nothing wakes
// - Reset rising edge restarts the watchdog timer
// - Chip select rising edge writes received word to addressed register
// - Chip select falling edge loads output status into shift register
// - Chip select high ignores clock and data, serial output released
// - Sample input on falling clock edge, change output on rising edge
// - Sixteen bits per frame, MSB first, both directions together
// - Five-bit address field inside each word selects the target register
// - Logic supply loss with detection enabled forces fail-safe mode
// - Select open: watchdog on, timeout makes outputs follow direct inputs
// - Select grounded: watchdog off, only supply failure with enable applies
// - Wake-up term is OR of reset, wake and qualified direct inputs
// - Fail: enabled supply failure, or watchdog timeout with select open
// - Fault term ORs channel flags, undervoltage and enabled overvoltage
// - Wake-up zero gives sleep with all outputs off
// - Wake-up, no fail, no fault gives normal mode
// - Wake-up with fail and no fault gives fail-safe mode
// - Wake-up with fault gives fault mode, faulted outputs off
// - Fail-safe drives outputs from inputs, config reverts to default
// - With both supplies present, wake-up and no fail or fault, the device enters normal mode
// - Fail-safe left on a word with watchdog bit one and supply good
// - In sleep all serial configuration reads as zero
`timescale 1ns/1ps
module spi_port_and_mode_control
   import lamp_ctrl_pkg::*;
#(
   parameter int unsigned WD_LIMIT = WD_CYCLES
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // Serial pins from host
   input  wire logic              cs_n_i,
   input  wire logic              sclk_i,
   input  wire logic              sdi_i,
   output logic                   sdo_o,
   output logic                   sdo_oe_n_o,
   // Device pins
   input  wire logic              reset_pin_i,
   input  wire logic              wake_i,
   input  wire logic [NCH-1:0]    direct_in_i,
   input  wire logic              failsafe_select_in_i,
   input  wire logic              battery_supply_i,
   input  wire chan_fault_s       chan_fault_i,
   input  wire supply_s           supply_i,
   input  wire logic [NCH-1:0]    out_status_i,
   // Results
   output logic [NCH-1:0]         high_side_output_o,
   output logic                   fault_flag_n_o,
   output logic                   fault_flag_oe_n_o,
   output op_mode_e               mode_o,
   output logic                   wr_strobe_o,
   output logic [ADDR_W-1:0]      wr_addr_o,
   output logic [DATA_W-1:0]      wr_data_o,
   output logic [NCH-1:0]         cfg_on_o
);

   // ======================================================================
   // Input synchronisers: two flops each for the serial, reset, wake, direct and select pins
   localparam int unsigned NSYNC = 9;
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   // Synchroniser flops take no reset value from the pins
   always_ff @(posedge clk_i) begin
      s1_q <= {direct_in_i, wake_i, reset_pin_i, sdi_i, sclk_i, cs_n_i};
      s2_q <= s1_q;
   end
   logic fsi_s1_q;
   logic fsi_s2_q;
   always_ff @(posedge clk_i) begin
      fsi_s1_q <= failsafe_select_in_i;
      fsi_s2_q <= fsi_s1_q;
   end

   wire       cs_n_s  = s2_q[0];
   wire       sclk_s  = s2_q[1];
   wire       sdi_s   = s2_q[2];
   wire       rst_s   = s2_q[3];
   wire       wake_s  = s2_q[4];
   wire [3:0] din_s   = s2_q[8:5];
   wire       fsi_open = fsi_s2_q;

   // ======================================================================
   // Edge detection on synchronised levels
   logic cs_n_d1_q;
   logic sclk_d1_q;
   logic rst_d1_q;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cs_n_d1_q <= 1'b1;
         sclk_d1_q <= 1'b0;
         rst_d1_q  <= 1'b0;
      end else begin
         cs_n_d1_q <= cs_n_s;
         sclk_d1_q <= sclk_s;
         rst_d1_q  <= rst_s;
      end
   end
   wire cs_fall   = cs_n_d1_q & ~cs_n_s;
   wire cs_rise   = ~cs_n_d1_q & cs_n_s;
   wire sclk_fall = sclk_d1_q & ~sclk_s & ~cs_n_s;
   wire sclk_rise = ~sclk_d1_q & sclk_s & ~cs_n_s;
   wire rst_rise  = ~rst_d1_q & rst_s;

   // ======================================================================
   // Shift register and bit counter
   logic [15:0]      rx_q;
   logic [15:0]      tx_q;
   logic [CNT_W-1:0] cnt_q;
   logic             sdo_q;
   logic             oe_n_q;
   wire  [15:0]      status_word = {12'h000, out_status_i};
   // Status captured at select fall; a frame is exactly sixteen samples
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rx_q   <= WORD_RST;
         tx_q   <= WORD_RST;
         cnt_q  <= '0;
         sdo_q  <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (cs_fall) begin
         tx_q   <= status_word;
         sdo_q  <= status_word[FRAME_BITS-1];
         cnt_q  <= '0;
         oe_n_q <= 1'b0;
      end else if (cs_n_s) begin
         oe_n_q <= 1'b1;
      end else begin
         if (sclk_fall) begin
            rx_q  <= {rx_q[14:0], sdi_s};
            // Saturate well above sixteen so an overlong frame stays rejected
            cnt_q <= (&cnt_q) ? cnt_q : cnt_q + 5'h01;
            tx_q  <= {tx_q[14:0], 1'b0};
         end
         if (sclk_rise && cnt_q != 5'h00) begin
            sdo_q <= tx_q[FRAME_BITS-1];
         end
      end
   end
   assign sdo_o      = sdo_q;
   assign sdo_oe_n_o = oe_n_q;

   // ======================================================================
   // Frame commit at chip select rise
   wire frame_ok = cs_rise & (cnt_q == FRAME_LEN);
   logic             wr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] data_q;
   logic             wd_last_q;
   logic             wd_kick;
   assign wd_kick = frame_ok & (rx_q[WD_BIT] != wd_last_q);
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !rst_s) begin
         wr_q      <= 1'b0;
         addr_q    <= '0;
         data_q    <= CFG_RST;
         wd_last_q <= 1'b0;
      end else begin
         wr_q <= frame_ok;
         if (frame_ok) begin
            addr_q    <= rx_q[ADDR_MSB:ADDR_LSB];
            data_q    <= rx_q[DATA_W-1:0];
            wd_last_q <= rx_q[WD_BIT];
         end
      end
   end

   // ======================================================================
   // Direct-input qualification, one filter per channel
   logic [NCH-1:0] in_on_q;
   for (genvar g = 0; g < NCH; g++) begin : g_qual
      logic [2:0] qc_q;
      always_ff @(posedge clk_i) begin
         if (!nrst_i) begin
            qc_q       <= '0;
            in_on_q[g] <= 1'b0;
         end else if (din_s[g] == in_on_q[g]) begin
            qc_q <= '0;
         end else if (qc_q == QUAL_MAX) begin
            qc_q       <= '0;
            in_on_q[g] <= din_s[g];
         end else begin
            qc_q <= qc_q + 3'h1;
         end
      end
   end

   // ======================================================================
   // Watchdog
   logic [31:0] wd_cnt_q;
   logic        wd_to_q;
   wire         wd_en = fsi_open;
   wire         wd_exit = frame_ok & rx_q[WD_BIT];
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !wd_en || rst_rise || wd_kick) begin
         wd_cnt_q <= '0;
         wd_to_q  <= 1'b0;
      end else if (wd_to_q) begin
         // Restart the count on exit, else the old count re-expires at once
         if (wd_exit) begin
            wd_cnt_q <= '0;
            wd_to_q  <= 1'b0;
         end
      end else if (wd_cnt_q >= WD_LIMIT - 1) begin
         wd_to_q <= 1'b1;
      end else begin
         wd_cnt_q <= wd_cnt_q + 32'h1;
      end
   end

   // ======================================================================
   // Mode terms
   wire wake_up = rst_s | wake_s | (|in_on_q);
   wire supply_fail = supply_i.logic_supply_fail &
                      supply_i.supply_fail_det_en;
   // Supply-caused fail-safe is held until the host sends the exit word
   // with the supply good; a new failure in that cycle wins over the exit
   logic sf_q;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sf_q <= 1'b0;
      end else if (supply_fail) begin
         sf_q <= 1'b1;
      end else if (wd_exit) begin
         sf_q <= 1'b0;
      end
   end
   wire fail_t  = supply_fail | sf_q | (wd_to_q & fsi_open);
   wire fault_t = (|chan_fault_i.overcurrent_flag) |
                  (|chan_fault_i.overtemp_flag) |
                  (|chan_fault_i.severe_short_flag) |
                  supply_i.undervoltage_flag |
                  (supply_i.overvoltage_flag &
                   supply_i.overvoltage_disable);
   wire [NCH-1:0] ch_fault = chan_fault_i.overcurrent_flag |
                             chan_fault_i.overtemp_flag |
                             chan_fault_i.severe_short_flag;

   op_mode_e mode_d;
   assign mode_d = (!wake_up || !battery_supply_i) ? MODE_SLEEP :
                   fault_t ? MODE_FAULT :
                   fail_t  ? MODE_FAILSAFE :
                             MODE_NORMAL;

   // ======================================================================
   // Configuration: per-channel on bits from address zero
   logic [NCH-1:0] cfg_on_q;
   wire cfg_clear = (mode_d == MODE_SLEEP) | (mode_d == MODE_FAILSAFE);
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !rst_s || cfg_clear) begin
         cfg_on_q <= '0;
      end else if (wr_q && addr_q == '0) begin
         cfg_on_q <= data_q[NCH-1:0];
      end
   end

   // Output selection per mode
   logic [NCH-1:0] hs_d;
   assign hs_d = (mode_d == MODE_NORMAL)   ? cfg_on_q :
                 (mode_d == MODE_FAILSAFE) ? din_s :
                 (mode_d == MODE_FAULT)    ? (cfg_on_q & ~ch_fault) :
                 '0;

   op_mode_e       mode_q;
   logic [NCH-1:0] hs_q;
   logic           ff_n_q;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mode_q <= MODE_SLEEP;
         hs_q   <= '0;
         ff_n_q <= 1'b1;
      end else begin
         mode_q <= mode_d;
         hs_q   <= hs_d;
         ff_n_q <= ~fault_t;
      end
   end
   assign mode_o             = mode_q;
   assign high_side_output_o = hs_q;
   // Data and enable from one flop: released high, pulled low on a fault
   assign fault_flag_n_o     = ff_n_q;
   assign fault_flag_oe_n_o  = ff_n_q;
   assign wr_strobe_o        = wr_q;
   assign wr_addr_o          = addr_q;
   assign wr_data_o          = data_q;
   assign cfg_on_o           = cfg_on_q;

   // ======================================================================
   // Checks
   chk_fault_flag_low: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      fault_t |=> !fault_flag_oe_n_o)
      else $error("fault flag not pulled");
   chk_sleep_off: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      !wake_up |=> high_side_output_o == '0)
      else $error("outputs on in sleep");
   chk_sdo_release: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (cs_n_s && !cs_fall) |=> sdo_oe_n_o)
      else $error("sdo driven");
   chk_short_frame: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (cs_rise && cnt_q != FRAME_LEN) |=> !wr_strobe_o)
      else $error("bad frame written");
   chk_frame_write: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (frame_ok && rst_s) |=> wr_strobe_o && wr_addr_o == $past(rx_q[14:10]))
      else $error("frame not written");
   chk_fault_mode: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (wake_up && battery_supply_i && fault_t) |=> mode_o == MODE_FAULT)
      else $error("fault mode missed");
   chk_failsafe_mode: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (wake_up && battery_supply_i && fail_t && !fault_t) |=>
      mode_o == MODE_FAILSAFE && high_side_output_o == $past(din_s))
      else $error("failsafe wrong");
   chk_wd_off: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      !fsi_open |=> !wd_to_q)
      else $error("watchdog ran grounded");
   cov_frame: cover property (@(posedge clk_i) frame_ok);
   cov_failsafe: cover property (@(posedge clk_i) mode_o == MODE_FAILSAFE);
   cov_fault: cover property (@(posedge clk_i) mode_o == MODE_FAULT);

endmodule

/* File: dv/spi_host_model.sv */
// Host microcontroller model that masters the serial port
`timescale 1ns/1ps
module spi_host_model (
   // Serial pins toward the device
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      sdi_o,
   input  wire logic sdo_i
);
   // =====================================================================
   // Idle: deselected with the clock parked low
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o  = 1'b0;
   end

   // One frame of n bits, 40 ns per clock phase
   task automatic xfer(input logic [15:0] w, input int n,
                       output logic [15:0] r);
      r = 16'h0000;
      cs_n_o = 1'b0; // Clock is low when select falls
      #40;
      for (int i = 0; i < n; i++) begin
         sclk_o = 1'b1;
         sdi_o = w[15-i]; // Most significant bit first
         #40;
         sclk_o = 1'b0;
         r = {r[14:0], sdo_i}; // Taken on the falling edge
         #40;
      end
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o; // Released line must not look like the last bit
      #400;
   endtask

   // Clock and data wiggle while deselected, which must be ignored
   task automatic stray();
      repeat (4) begin
         sclk_o = 1'b1;
         sdi_o = ~sdi_o;
         #40;
         sclk_o = 1'b0;
         #40;
      end
   endtask
endmodule

/* File: dv/spi_port_and_mode_control_tb.sv */
// Self-checking bench for the serial port and mode control
`timescale 1ns/1ps
module spi_port_and_mode_control_tb;
   import lamp_ctrl_pkg::*;
   // =====================================================================
   // Signals
   localparam int unsigned WDL = 2000; // Shortened watchdog timeout
   logic              clk_i, nrst_i, cs_n, sclk, sdi, sdo, sdo_oe_n;
   logic              rst_pin, wake, fs_sel, bat, ff_n, ff_oe_n, stb;
   logic [NCH-1:0]    din, ostat, hs, cfg_on;
   chan_fault_s       cf;
   supply_s           sup;
   op_mode_e          mode;
   logic [ADDR_W-1:0] waddr;
   logic [DATA_W-1:0] wdata;
   logic [15:0]       r;
   int                miscompares, compares, cyc, nstb;
   wire               sdo_line  = sdo_oe_n ? 1'bz : sdo;
   wire               flag_line = ff_oe_n ? 1'b1 : ff_n; // Pull-up

   // =====================================================================
   // Design and host
   spi_port_and_mode_control #(.WD_LIMIT(WDL)) i_dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sclk_i(sclk),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
      .reset_pin_i(rst_pin), .wake_i(wake), .direct_in_i(din),
      .failsafe_select_in_i(fs_sel), .battery_supply_i(bat),
      .chan_fault_i(cf), .supply_i(sup), .out_status_i(ostat),
      .high_side_output_o(hs), .fault_flag_n_o(ff_n),
      .fault_flag_oe_n_o(ff_oe_n), .mode_o(mode), .wr_strobe_o(stb),
      .wr_addr_o(waddr), .wr_data_o(wdata), .cfg_on_o(cfg_on));
   spi_host_model i_host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
      .sdo_i(sdo_line));

   // Clock, strobe counter and hang guard
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (stb === 1'b1) nstb <= nstb + 1;
      if (cyc == 30000) begin
         miscompares++;
         finish_test();
      end
   end

   // =====================================================================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait for a mode, then let registered outputs settle
   task automatic wmode(input op_mode_e m, input int lim);
      for (int i = 0; i < lim && mode !== m; i++) @(negedge clk_i);
      repeat (10) @(negedge clk_i);
      chk(16'(mode), 16'(m));
   endtask
   // Only a full sixteen-bit frame may produce a write
   task automatic send(input logic [15:0] w, input int n);
      int s;
      s = nstb;
      @(negedge clk_i);
      i_host.xfer(w, n, r);
      chk(16'(nstb - s), (n == 16) ? 16'h1 : 16'h0);
   endtask
   task automatic finish_test();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // =====================================================================
   // Main sequence
   initial begin
      nrst_i = 1'b0; rst_pin = 1'b0; wake = 1'b0; fs_sel = 1'b0;
      bat = 1'b1; din = 4'h0; ostat = 4'h5; cf = '0; sup = '0;
      miscompares = 0; compares = 0; cyc = 0; nstb = 0;
      repeat (20) @(negedge clk_i);
      nrst_i = 1'b1;
      chk(16'(mode), 16'(MODE_SLEEP));
      rst_pin = 1'b1;
      wmode(MODE_NORMAL, 60);
      send(16'h000a, 16);
      chk(16'(r[3:0]), 16'(ostat));
      chk(16'(hs), 16'h000a);
      send(16'h0005, 15);
      chk(16'(cfg_on), 16'h000a);
      send(16'h0d55, 16);
      chk({1'b0, waddr, wdata}, 16'h0d55);
      i_host.stray();
      chk({15'h0, sdo_oe_n}, 16'h0001);
      send(16'h000a, 16);
      // Each fault source in turn, channel 1 being on
      for (int k = 0; k < 5; k++) begin
         case (k)
            0: cf.overcurrent_flag = 4'h2;
            1: cf.overtemp_flag = 4'h2;
            2: cf.severe_short_flag = 4'h2;
            3: sup.undervoltage_flag = 1'b1;
            default: sup = 5'b01100;
         endcase
         wmode(MODE_FAULT, 60);
         chk(16'(flag_line), 16'h0000);
         if (k < 3) chk(16'(hs), 16'h0008);
         cf = '0;
         sup = '0;
         wmode(MODE_NORMAL, 60);
         chk(16'(flag_line), 16'h0001);
      end
      sup.overvoltage_flag = 1'b1; // Not armed by its qualifier
      wmode(MODE_NORMAL, 20);
      // Logic supply loss with detection enabled
      din = 4'h6;
      sup = 5'b00011;
      wmode(MODE_FAILSAFE, 60);
      chk({8'h00, hs, cfg_on}, 16'h0060);
      sup = '0;
      din = 4'h0;
      // Supply good alone must not leave fail-safe
      wmode(MODE_FAILSAFE, 20);
      send(16'h8000, 16);
      wmode(MODE_NORMAL, 60);
      // Watchdog kept alive by toggling, then left to expire
      fs_sel = 1'b1;
      send(16'h000a, 16);
      send(16'h800a, 16);
      send(16'h000a, 16);
      send(16'h800a, 16);
      chk(16'(mode), 16'(MODE_NORMAL));
      wmode(MODE_FAILSAFE, 2200);
      chk(16'(cfg_on), 16'h0000);
      send(16'h8000, 16);
      wmode(MODE_NORMAL, 60);
      // Grounded select keeps the watchdog quiet
      fs_sel = 1'b0;
      send(16'h000a, 16);
      repeat (2200) @(negedge clk_i);
      chk(16'(mode), 16'(MODE_NORMAL));
      rst_pin = 1'b0;
      wmode(MODE_SLEEP, 60);
      chk({8'h00, hs, cfg_on}, 16'h0000);
      // Wake pin alone, battery loss, then a qualified direct input
      wake = 1'b1;
      wmode(MODE_NORMAL, 60);
      bat = 1'b0;
      wmode(MODE_SLEEP, 20);
      bat = 1'b1;
      wmode(MODE_NORMAL, 20);
      wake = 1'b0;
      wmode(MODE_SLEEP, 60);
      din = 4'h2;
      repeat (2) @(negedge clk_i);
      din = 4'h0;
      wmode(MODE_SLEEP, 20);
      din = 4'h1;
      wmode(MODE_NORMAL, 60);
      finish_test();
   end
endmodule
